//--- src/smad_map.svh
// offsets, field positions, reset values and address bounds of the memory decoder
`ifndef SMAD_MAP_SVH
`define SMAD_MAP_SVH

// configuration space offsets
`define SMAD_OFF_PAM0     8'h40
`define SMAD_OFF_PAM1     8'h41
`define SMAD_OFF_PAM2     8'h42
`define SMAD_OFF_PAM3     8'h43
`define SMAD_OFF_HOLE     8'h44
`define SMAD_OFF_TOM_LO   8'h45
`define SMAD_OFF_TOM_HI   8'h46
`define SMAD_OFF_MANAGEMENT_RAM    8'h47
`define SMAD_OFF_DECMODE  8'h48
`define SMAD_OFF_BIOS_EN  8'he3

// field positions in the bios decode enable byte
`define SMAD_E3_TOP_BIT   0
`define SMAD_E3_EN_LSB    1

// reset values and the top of dram limit
`define SMAD_PAM_RST      26'h000_0000
`define SMAD_HOLE_RST     1'b0
`define SMAD_TOM_RST      9'h008
`define SMAD_TOM_MAX      9'h100
`define SMAD_MANAGEMENT_RAM_RST    1'b1
`define SMAD_DECMODE_RST  1'b0
`define SMAD_BIOS_EN_RST  4'hf

// address bounds, each the first address above a range, except SMAD_IO_LAST, the last i/o location
`define SMAD_DOS_END      32'h0008_0000
`define SMAD_HOLE_END     32'h000a_0000
`define SMAD_VGA_END      32'h000c_0000
`define SMAD_EXP_END      32'h000e_0000
`define SMAD_EXT_BASE     32'h0010_0000
`define SMAD_RSV_BASE     32'hfec0_0000
`define SMAD_RSV_END      32'hfed0_0000
`define SMAD_HBIOS_BASE   32'hffc0_0000
`define SMAD_TOP64_BASE   32'hffff_0000
`define SMAD_IO_LAST      17'h1_0002

`endif

//--- src/smad_pkg.sv
// types shared by the memory decoder modules
package smad_pkg;

	typedef enum logic [1:0] {
		SMAD_TGT_DRAM = 2'b00,
		SMAD_TGT_PCI  = 2'b01,
		SMAD_TGT_ROM  = 2'b11
	} smad_tgt_t;

	typedef enum logic [1:0] {
		SMAD_ORG_NORTH = 2'b00,
		SMAD_ORG_SOUTH = 2'b01,
		SMAD_ORG_EXT   = 2'b11
	} smad_org_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic        write;
		logic        from_pci;
		logic        system_management_state;
	} smad_req_t;

	typedef struct packed {
		logic      valid;
		smad_tgt_t tgt;
		logic      reserved_hit;
	} smad_rsp_t;

	typedef struct packed {
		logic      valid;
		smad_org_t origin;
		logic      north_hit;
		logic      south_hit;
	} smad_b0_t;

	typedef struct packed {
		logic valid;
		logic south_claim;
		logic north_claim;
		logic ext_bcast;
	} smad_claim_t;

	typedef struct packed {
		logic [25:0] segment_attribute_map;
		logic        fixed_hole;
		logic [8:0]  tom_mb;
		logic        smm_vga_dram;
		logic        south_subtr;
		logic [3:0]  bios_en;
	} smad_cfg_t;

	typedef struct packed {
		smad_cfg_t   cfg;
		smad_rsp_t   rsp;
		smad_claim_t claim;
		logic [7:0]  cfg_rdata;
		logic        cfg_ack;
		logic        io_done;
		logic        io_ok;
	} smad_state_t;

endpackage

//--- src/smad_seg_attr.sv
// attribute lookup for the thirteen compatibility segments
`timescale 1ns/1ns
module smad_seg_attr
	import smad_pkg::*;
(
	input  wire logic [31:0] addr,    // access address
	input  wire logic [25:0] segment_attribute_map,     // two bits per segment, {we, re}
	output logic             seg_hit, // address lies in c0000..fffff
	output logic             we,      // write goes to dram
	output logic             re       // read goes to dram
);

	logic [3:0] idx;
	logic [3:0] seg;

	// c0000..effff are 16 KB segments 0..11, f0000..fffff one segment 12
	always_comb
	begin
		idx     = addr[17:14];
		seg_hit = (addr[31:20] == 12'h000) && (addr[19:18] == 2'b11); // RULE18
		seg     = (idx >= 4'hc) ? 4'hc : idx;
		we      = segment_attribute_map[{seg, 1'b1}];
		re      = segment_attribute_map[{seg, 1'b0}];
	end

endmodule

//--- src/smad_bus0.sv
// claim and broadcast decision for a cycle seen on internal bus 0
`timescale 1ns/1ns
module smad_bus0
	import smad_pkg::*;
(
	input  wire smad_b0_t    cyc,         // cycle on internal bus 0
	input  wire logic        south_subtr, // south cluster decodes subtractively
	output smad_claim_t      claim        // who takes the cycle
);

	always_comb
	begin
		claim       = '0;
		claim.valid = cyc.valid;
		if (cyc.valid)
		begin
			// south never claims its own cycle
			if (cyc.origin != SMAD_ORG_SOUTH)
			begin
				// subtractive: take what the north cluster does not claim
				if (south_subtr)
					claim.south_claim = !(cyc.origin == SMAD_ORG_EXT && cyc.north_hit); // RULE15
				else
					claim.south_claim = cyc.south_hit; // RULE15
			end
			// north only claims on a positive address match
			if (cyc.origin != SMAD_ORG_NORTH)
				claim.north_claim = cyc.north_hit; // RULE16
			// cluster to cluster traffic is mirrored outside
			claim.ext_bcast = (cyc.origin != SMAD_ORG_EXT); // RULE17
		end
	end

endmodule

//--- src/smad_decoder.sv
// system memory address decoder with its configuration registers
//
// Summary of operation
// (RULE1) 32-bit memory space, 64K+3 I/O locations
// (RULE2) 0..7FFFFh always goes to dram
// (RULE3) 80000h..9FFFFh dram, or pci when hole
// (RULE4) video range pci normally, dram in smm
// (RULE5) attributes never affect the video range
// (RULE6) management ram control steers smm video access
// (RULE7) eight 16 KB expansion segments, four modes
// (RULE8) disabled segment dram is simply unreachable
// (RULE9) e/f range: read/write attributes pick dram/rom
// (RULE10) 1 MB to top of dram goes dram
// (RULE11) above top of dram to FEBFFFFF: pci
// (RULE12) FEC00000 range reserved, never dram or rom
// (RULE13) FFC00000..FFFEFFFF rom or pci per E3h
// (RULE14) top 64 KB always rom, bit reads 1
// (RULE15) south claims bus 0 positively or subtractively
// (RULE16) north claims bus 0 only on match
// (RULE17) cluster cycles broadcast onto external pci
// (RULE18) thirteen segments with separate read/write enables
// (RULE19) f0000h segment disabled after reset
// (RULE20) extended bios segments: separate read/write attributes
// (RULE21) each access gets exactly one target
//
// address map, first match wins
//   00000000..0007ffff  dram
//   00080000..0009ffff  dram, pci when fixed hole set
//   000a0000..000bffff  pci, dram for processor in smm with 47h bit0
//   000c0000..000dffff  eight segments, dram or pci
//   000e0000..000effff  four segments, dram or rom
//   000f0000..000fffff  one segment, dram or rom
//   00100000..top       dram
//   top..febfffff       pci
//   fec00000..fecfffff  reserved, pci with flag
//   fed00000..ffbfffff  pci
//   ffc00000..fffeffff  rom or pci, one e3h bit per 1 MB
//   ffff0000..ffffffff  rom
//   i/o space 00000h..10002h, wrap locations included
//
// configuration bytes
//   40h..43h  segment_attribute_map, two bits per segment {we, re}
//   44h       bit0 fixed_hole_control
//   45h, 46h  top_of_dram in MB, nine bits, clamped to 256
//   47h       bit0 management_ram video steering
//   48h       bit0 south cluster subtractive mode
//   e3h       bios_rom_decode_enables, bit0 wired high
//
// every answer is registered, one cycle after its request;
// config writes take effect for accesses on the next edge
// limitation: extended smm and high bios alias are not decoded here
`timescale 1ns/1ns
`include "smad_map.svh"
module smad_decoder
	import smad_pkg::*;
(
	input  wire logic        clk_sys,          // bridge clock, 125 MHz
	input  wire logic        nrst,             // synchronous reset, low
	input  wire logic        cfg_sel,          // configuration access this cycle
	input  wire logic        cfg_wr,           // 1 write, 0 read
	input  wire logic [7:0]  cfg_addr,         // configuration byte offset
	input  wire logic [7:0]  cfg_wdata,        // write byte
	output logic      [7:0]  cfg_rdata,        // read byte
	output logic             cfg_ack,          // access done pulse
	input  wire smad_req_t   mem_req,          // memory access to route
	output logic             mem_done,         // routing valid pulse
	output smad_tgt_t        mem_tgt,          // chosen target
	output logic             mem_reserved,     // access hit reserved range
	input  wire logic        io_valid,         // i/o access request
	input  wire logic [16:0] io_addr,          // i/o byte address
	output logic             io_done,          // i/o check valid pulse
	output logic             io_ok,            // address within i/o space
	input  wire smad_b0_t    b0_cyc,           // cycle on internal bus 0
	output logic             b0_done,          // claim result valid pulse
	output logic             b0_south_claim,   // south cluster claims
	output logic             b0_north_claim,   // north cluster claims
	output logic             b0_ext_bcast      // cycle copied outside
);

	// the whole block state, one register
	smad_state_t s;
	smad_state_t next_s;

	// lookup results for the current access
	logic        seg_hit;
	logic        seg_we;
	logic        seg_re;
	smad_claim_t b0_claim;

	// segment attribute lookup for the access being routed
	// both attribute bits are looked up; route() picks by direction
	smad_seg_attr u_seg
	(
		.addr    (mem_req.addr),
		.segment_attribute_map     (s.cfg.segment_attribute_map),
		.seg_hit (seg_hit),
		.we      (seg_we),
		.re      (seg_re)
	);

	// bus 0 claim decision
	// registered one cycle later, like every other answer
	smad_bus0 u_bus0
	(
		.cyc         (b0_cyc),
		.south_subtr (s.cfg.south_subtr),
		.claim       (b0_claim)
	);

	// first byte above dram; value is clamped to 256 MB on write
	function automatic logic [31:0] tom_bound
	(
		input logic [8:0] tom_mb
	);
		tom_bound = {3'b000, tom_mb, 20'h0_0000};
	endfunction

	// clamp a top of dram value to the largest legal size
	// larger values would claim dram that cannot exist
	function automatic logic [8:0] tom_clamp
	(
		input logic [8:0] tom_mb
	);
		tom_clamp = (tom_mb > `SMAD_TOM_MAX) ? `SMAD_TOM_MAX : tom_mb; // RULE10
	endfunction

	// true inside the reserved block; shared by routing and the flag
	function automatic logic in_reserved
	(
		input logic [31:0] a
	);
		in_reserved = (a >= `SMAD_RSV_BASE) && (a < `SMAD_RSV_END);
	endfunction

	// read image of the bios decode enable byte
	// bits 7:5 are unused and read zero
	function automatic logic [7:0] bios_byte
	(
		input logic [3:0] bios_en
	);
		bios_byte                  = 8'h00;
		bios_byte[`SMAD_E3_EN_LSB +: 4] = bios_en;
		bios_byte[`SMAD_E3_TOP_BIT] = 1'b1; // RULE14
	endfunction

	// configuration read mux; unmapped offsets read zero
	// reserved bits of each byte read as zero
	function automatic logic [7:0] cfg_read
	(
		input logic [7:0] a,
		input smad_cfg_t  c
	);
		case (a)
			`SMAD_OFF_PAM0:    cfg_read = c.segment_attribute_map[7:0];
			`SMAD_OFF_PAM1:    cfg_read = c.segment_attribute_map[15:8];
			`SMAD_OFF_PAM2:    cfg_read = c.segment_attribute_map[23:16];
			`SMAD_OFF_PAM3:    cfg_read = {6'b00_0000, c.segment_attribute_map[25:24]};
			`SMAD_OFF_HOLE:    cfg_read = {7'h00, c.fixed_hole};
			`SMAD_OFF_TOM_LO:  cfg_read = c.tom_mb[7:0];
			`SMAD_OFF_TOM_HI:  cfg_read = {7'h00, c.tom_mb[8]};
			`SMAD_OFF_MANAGEMENT_RAM:   cfg_read = {7'h00, c.smm_vga_dram};
			`SMAD_OFF_DECMODE: cfg_read = {7'h00, c.south_subtr};
			`SMAD_OFF_BIOS_EN: cfg_read = bios_byte(c.bios_en);
			default:           cfg_read = 8'h00;
		endcase
	endfunction

	// the routing decision; the if-chain makes one target per access
	function automatic smad_tgt_t route
	(
		input smad_req_t r,
		input smad_cfg_t c,
		input logic      we,
		input logic      re
	);
		logic en;
		logic cpu_smm;
		en      = r.write ? we : re;
		// only the processor can be in management mode
		cpu_smm = r.system_management_state && !r.from_pci;
		// low dos area: fixed, no control applies
		if (r.addr < `SMAD_DOS_END)
			route = SMAD_TGT_DRAM; // RULE2
		// upper dos area: optional hole
		else if (r.addr < `SMAD_HOLE_END)
			route = c.fixed_hole ? SMAD_TGT_PCI : SMAD_TGT_DRAM; // RULE3
		// video buffer: steered by smm state and 47h bit0 only
		else if (r.addr < `SMAD_VGA_END)
		begin
			// attributes are not consulted here
			if (cpu_smm && c.smm_vga_dram) // RULE6
				route = SMAD_TGT_DRAM; // RULE4
			else
				route = SMAD_TGT_PCI; // RULE5
		end
		// expansion area: disabled segments go out to pci
		else if (r.addr < `SMAD_EXP_END)
			// a disabled segment falls through to pci, dram is not moved
			route = en ? SMAD_TGT_DRAM : SMAD_TGT_PCI; // RULE7 RULE8
		// bios area below 1 MB: disabled means rom
		else if (r.addr < `SMAD_EXT_BASE)
			route = en ? SMAD_TGT_DRAM : SMAD_TGT_ROM; // RULE9 RULE20
		// main dram above 1 MB up to top of dram
		else if (r.addr < tom_bound(c.tom_mb))
			route = SMAD_TGT_DRAM; // RULE10
		// pci hole between dram and the reserved block
		else if (r.addr < `SMAD_RSV_BASE)
			route = SMAD_TGT_PCI; // RULE11
		// reserved: sent to pci so nothing inside answers
		else if (in_reserved(r.addr))
			route = SMAD_TGT_PCI; // RULE12
		// pci above the reserved block
		else if (r.addr < `SMAD_HBIOS_BASE)
			route = SMAD_TGT_PCI;
		// high bios: one enable bit per 1 MB
		else if (r.addr < `SMAD_TOP64_BASE)
			route = c.bios_en[r.addr[21:20]] ? SMAD_TGT_ROM : SMAD_TGT_PCI; // RULE13
		// top 64 KB: always rom
		else
			route = SMAD_TGT_ROM; // RULE14
	endfunction

	// values of every flop after reset
	// pam all zero: every segment, f0000 too, starts disabled
	function automatic smad_state_t reset_state();
		smad_state_t z;
		z                  = '0;
		z.cfg.segment_attribute_map          = `SMAD_PAM_RST; // RULE19
		z.cfg.fixed_hole   = `SMAD_HOLE_RST;
		z.cfg.tom_mb       = `SMAD_TOM_RST;
		z.cfg.smm_vga_dram = `SMAD_MANAGEMENT_RAM_RST;
		z.cfg.south_subtr  = `SMAD_DECMODE_RST;
		z.cfg.bios_en      = `SMAD_BIOS_EN_RST;
		z.rsp.tgt          = SMAD_TGT_DRAM;
		reset_state        = z;
	endfunction

	// next state: configuration access, routing, i/o check, bus 0
	always_comb
	begin
		next_s = s;

		// pulses last one cycle
		next_s.cfg_ack = 1'b0;
		next_s.io_done = 1'b0;

		// configuration write; read-only and reserved bits drop out
		// a write to 45h or 46h clamps the whole nine-bit value,
		// so lowering the size from 256 needs 46h written before 45h
		if (cfg_sel && cfg_wr)
		begin
			case (cfg_addr)
				`SMAD_OFF_PAM0:
					next_s.cfg.segment_attribute_map[7:0] = cfg_wdata; // RULE18
				`SMAD_OFF_PAM1:
					next_s.cfg.segment_attribute_map[15:8] = cfg_wdata;
				`SMAD_OFF_PAM2:
					next_s.cfg.segment_attribute_map[23:16] = cfg_wdata;
				`SMAD_OFF_PAM3:
					next_s.cfg.segment_attribute_map[25:24] = cfg_wdata[1:0];
				`SMAD_OFF_HOLE:
					next_s.cfg.fixed_hole = cfg_wdata[0];
				`SMAD_OFF_TOM_LO:
					next_s.cfg.tom_mb = tom_clamp({s.cfg.tom_mb[8], cfg_wdata});
				`SMAD_OFF_TOM_HI:
					next_s.cfg.tom_mb = tom_clamp({cfg_wdata[0], s.cfg.tom_mb[7:0]});
				`SMAD_OFF_MANAGEMENT_RAM:
					next_s.cfg.smm_vga_dram = cfg_wdata[0];
				`SMAD_OFF_DECMODE:
					next_s.cfg.south_subtr = cfg_wdata[0];
				`SMAD_OFF_BIOS_EN:
					// top 64 KB bit is wired, not stored
					next_s.cfg.bios_en = cfg_wdata[`SMAD_E3_EN_LSB +: 4];
				default:
					next_s.cfg = s.cfg;
			endcase
		end

		// every access is acknowledged; reads return the old value
		// read data holds until the next read, writes leave it
		if (cfg_sel)
		begin
			next_s.cfg_ack = 1'b1;
			if (!cfg_wr)
				next_s.cfg_rdata = cfg_read(cfg_addr, s.cfg);
		end

		// memory routing, one cycle from request to answer
		// a pci master never carries smm; route() masks it anyway
		next_s.rsp.valid = mem_req.valid;
		if (mem_req.valid)
		begin
			next_s.rsp.tgt = route(mem_req, s.cfg, seg_we, seg_re); // RULE21
			next_s.rsp.reserved_hit = in_reserved(mem_req.addr); // RULE12
		end
		else
			next_s.rsp.reserved_hit = 1'b0;

		// i/o space reaches 64K+3 through the wrap locations
		if (io_valid)
		begin
			next_s.io_done = 1'b1;
			next_s.io_ok   = (io_addr <= `SMAD_IO_LAST); // RULE1
		end

		// bus 0 claim result, registered
		next_s.claim = b0_claim;
	end

	// single state register with synchronous reset
	// nrst must be held for at least one edge;
	// the first request may follow on the first edge with nrst high
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
			s <= reset_state();
		else
			s <= next_s;
	end

	// outputs straight from the state flops
	// no logic between flop and pin keeps output timing flat
	assign cfg_rdata      = s.cfg_rdata;
	assign cfg_ack        = s.cfg_ack;
	assign mem_done       = s.rsp.valid;
	assign mem_tgt        = s.rsp.tgt;
	assign mem_reserved   = s.rsp.reserved_hit;
	assign io_done        = s.io_done;
	assign io_ok          = s.io_ok;
	assign b0_done        = s.claim.valid;
	assign b0_south_claim = s.claim.south_claim;
	assign b0_north_claim = s.claim.north_claim;
	assign b0_ext_bcast   = s.claim.ext_bcast;

endmodule

//--- bench/smad_decoder_properties.sv
// port-level checks of the memory decoder, bound to its top module
`timescale 1ns/1ns
module smad_decoder_properties
	import smad_pkg::*;
(
	input wire logic        clk_sys,        // clock
	input wire logic        nrst,           // reset, low
	input wire logic        cfg_sel,        // config access
	input wire logic        cfg_wr,         // config write
	input wire logic [7:0]  cfg_addr,       // offset
	input wire logic [7:0]  cfg_wdata,      // write byte
	input wire logic [7:0]  cfg_rdata,      // read byte
	input wire logic        cfg_ack,        // config done
	input wire smad_req_t   mem_req,        // access
	input wire logic        mem_done,       // routed
	input wire smad_tgt_t   mem_tgt,        // target
	input wire logic        mem_reserved,   // reserved hit
	input wire logic        io_valid,       // i/o request
	input wire logic [16:0] io_addr,        // i/o address
	input wire logic        io_done,        // i/o checked
	input wire logic        io_ok,          // i/o in range
	input wire smad_b0_t    b0_cyc,         // bus 0 cycle
	input wire logic        b0_done,        // claim valid
	input wire logic        b0_south_claim, // south takes
	input wire logic        b0_north_claim, // north takes
	input wire logic        b0_ext_bcast    // copied outside
);
	// one domain, so clock and reset are given once
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	a_cfg_ack_next: assert property (cfg_sel |=> cfg_ack)
		else $error("config ack not one cycle after access");
	a_cfg_ack_pulse: assert property (!cfg_sel |=> !cfg_ack)
		else $error("config ack without an access");
	a_mem_done_next: assert property (mem_req.valid |=> mem_done)
		else $error("memory route not given one cycle later");
	a_dos_low_dram: assert property (mem_req.valid && mem_req.addr < 32'h0008_0000 |=> mem_tgt == SMAD_TGT_DRAM)
		else $error("low dos access not sent to dram");
	a_video_norm_pci: assert property (mem_req.valid && !mem_req.system_management_state && mem_req.addr[31:17] == 15'h0005
		|=> mem_tgt == SMAD_TGT_PCI)
		else $error("normal video access not sent to pci");
	a_top_block_rom: assert property (mem_req.valid && mem_req.addr >= 32'hffff_0000 |=> mem_tgt == SMAD_TGT_ROM)
		else $error("top block not sent to rom");
	a_reserved_flag: assert property (mem_req.valid && mem_req.addr[31:20] == 12'hfec
		|=> mem_reserved && mem_tgt == SMAD_TGT_PCI)
		else $error("reserved range not flagged");
	a_above_max_pci: assert property (mem_req.valid && mem_req.addr >= 32'h1000_0000 && mem_req.addr < 32'hfec0_0000
		|=> mem_tgt == SMAD_TGT_PCI)
		else $error("access above dram limit not sent to pci");
	a_io_bound: assert property (io_valid |=> io_done && io_ok == ($past(io_addr) <= 17'h1_0002))
		else $error("i/o range check wrong");
	a_north_match: assert property (b0_cyc.valid && !b0_cyc.north_hit |=> !b0_north_claim)
		else $error("north claimed without match");
	a_cluster_bcast: assert property (b0_cyc.valid && b0_cyc.origin != SMAD_ORG_EXT |=> b0_done && b0_ext_bcast)
		else $error("cluster cycle not broadcast");

	c_smm_access: cover property (mem_req.valid && mem_req.system_management_state);
	c_cfg_write: cover property (cfg_sel && cfg_wr);
	c_south_claim: cover property (b0_south_claim);
endmodule

bind smad_decoder smad_decoder_properties i_smad_decoder_properties (.clk_sys, .nrst, .cfg_sel, .cfg_wr, .cfg_addr,
	.cfg_wdata, .cfg_rdata, .cfg_ack, .mem_req, .mem_done, .mem_tgt, .mem_reserved, .io_valid, .io_addr, .io_done,
	.io_ok, .b0_cyc, .b0_done, .b0_south_claim, .b0_north_claim, .b0_ext_bcast);

//--- bench/smad_host.sv
// host and pci master model issuing memory accesses
`timescale 1ns/1ns
module smad_host
	import smad_pkg::*;
(
	input  wire logic clk_sys, // bridge clock
	output smad_req_t mem_req  // access to route
);
	initial mem_req = '0;
	// address scrambled once released, so a stale value never matches by luck
	task automatic issue(input logic [31:0] a, input logic w, input logic p, input logic s, input int gap);
		repeat (gap) @(posedge clk_sys);
		@(posedge clk_sys);
		mem_req <= '{1'b1, a, w, p, s};
		@(posedge clk_sys);
		mem_req.valid <= 1'b0;
		mem_req.addr  <= ~a;
	endtask
endmodule

//--- bench/smad_decoder_bench.sv
// self-checking bench for the memory decoder
`timescale 1ns/1ns
module smad_decoder_bench;
	import smad_pkg::*;
	logic        clk_sys, nrst, cfg_sel, cfg_wr, cfg_ack, mem_done, mem_reserved, io_valid, io_done, io_ok;
	logic        b0_done, b0_south_claim, b0_north_claim, b0_ext_bcast;
	logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata;
	logic [16:0] io_addr;
	smad_req_t   mem_req;
	smad_tgt_t   mem_tgt;
	smad_b0_t    b0_cyc;
	int          bad_count = 0;
	int          n_compared = 0;

	smad_decoder i_smad_decoder (.clk_sys, .nrst, .cfg_sel, .cfg_wr, .cfg_addr, .cfg_wdata, .cfg_rdata, .cfg_ack,
		.mem_req, .mem_done, .mem_tgt, .mem_reserved, .io_valid, .io_addr, .io_done, .io_ok, .b0_cyc, .b0_done,
		.b0_south_claim, .b0_north_claim, .b0_ext_bcast);
	smad_host i_smad_host (.clk_sys, .mem_req);

	// 125 MHz clock
	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one config access; ack lands exactly one cycle later
	task automatic cfg(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		cfg_sel   <= 1'b1;
		cfg_wr    <= w;
		cfg_addr  <= a;
		cfg_wdata <= d;
		@(posedge clk_sys);
		cfg_sel <= 1'b0;
		#1 chk("cfg_ack", 1, cfg_ack);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		cfg(1'b0, a, 8'h00);
		chk("cfg_rdata", exp, cfg_rdata);
	endtask

	// route one access; writes wait two extra cycles before issue, reads none
	task automatic rt(input logic [31:0] a, input logic w, input logic p, input logic s, input smad_tgt_t exp);
		i_smad_host.issue(a, w, p, s, w ? 2 : 0);
		#1 chk("mem_done", 1, mem_done);
		chk("mem_tgt", exp, mem_tgt);
		chk("mem_reserved", a[31:20] == 12'hfec, mem_reserved);
	endtask

	task automatic io(input logic [16:0] a, input logic exp);
		@(posedge clk_sys);
		io_valid <= 1'b1;
		io_addr  <= a;
		@(posedge clk_sys);
		io_valid <= 1'b0;
		io_addr  <= ~a;
		#1 chk("io_done", 1, io_done);
		chk("io_ok", exp, io_ok);
	endtask

	// broadcast is judged for cluster cycles only
	task automatic b0(input smad_org_t o, input logic nh, input logic sh, input logic [1:0] exp);
		@(posedge clk_sys);
		b0_cyc <= '{1'b1, o, nh, sh};
		@(posedge clk_sys);
		b0_cyc <= '0;
		#1 chk("b0_done", 1, b0_done);
		chk("b0_claims", exp, {b0_south_claim, b0_north_claim});
		if (o != SMAD_ORG_EXT)
			chk("b0_ext_bcast", 1, b0_ext_bcast);
	endtask

	task automatic t_reset_map;
		rd(8'he3, 8'h1f);
		rd(8'h10, 8'h00);
		rt(32'h0007_ffff, 1'b1, 1'b0, 1'b0, SMAD_TGT_DRAM);
		rt(32'h0008_0000, 1'b0, 1'b0, 1'b0, SMAD_TGT_DRAM);
		rt(32'h000a_0000, 1'b0, 1'b0, 1'b0, SMAD_TGT_PCI);
		rt(32'h000b_ffff, 1'b0, 1'b0, 1'b1, SMAD_TGT_DRAM);
		rt(32'h000c_0000, 1'b0, 1'b0, 1'b0, SMAD_TGT_PCI);
		rt(32'h000e_0000, 1'b0, 1'b0, 1'b0, SMAD_TGT_ROM);
		rt(32'h000f_0000, 1'b1, 1'b0, 1'b0, SMAD_TGT_ROM);
		rt(32'h007f_ffff, 1'b0, 1'b0, 1'b0, SMAD_TGT_DRAM);
		rt(32'h0080_0000, 1'b0, 1'b0, 1'b0, SMAD_TGT_PCI);
		rt(32'hfebf_ffff, 1'b0, 1'b0, 1'b0, SMAD_TGT_PCI);
		rt(32'hfec0_0000, 1'b0, 1'b0, 1'b0, SMAD_TGT_PCI);
		rt(32'hffc0_0000, 1'b0, 1'b0, 1'b0, SMAD_TGT_ROM);
		rt(32'hffff_0000, 1'b0, 1'b0, 1'b0, SMAD_TGT_ROM);
		$display("test reset_map done");
	endtask

	task automatic t_attr;
		cfg(1'b1, 8'h44, 8'h01);
		rt(32'h0009_ffff, 1'b0, 1'b0, 1'b0, SMAD_TGT_PCI);
		cfg(1'b1, 8'h40, 8'h01);
		rt(32'h000c_0000, 1'b0, 1'b0, 1'b0, SMAD_TGT_DRAM);
		rt(32'h000c_3fff, 1'b1, 1'b0, 1'b0, SMAD_TGT_PCI);
		rt(32'h000c_4000, 1'b0, 1'b0, 1'b0, SMAD_TGT_PCI);
		cfg(1'b1, 8'h42, 8'h02);
		rt(32'h000e_0000, 1'b1, 1'b0, 1'b0, SMAD_TGT_DRAM);
		rt(32'h000e_0000, 1'b0, 1'b0, 1'b0, SMAD_TGT_ROM);
		cfg(1'b1, 8'h43, 8'h03);
		rt(32'h000f_ffff, 1'b0, 1'b0, 1'b0, SMAD_TGT_DRAM);
		rt(32'h000a_0000, 1'b1, 1'b0, 1'b0, SMAD_TGT_PCI);
		$display("test attr done");
	endtask

	task automatic t_smm_tom;
		rt(32'h000a_0000, 1'b0, 1'b1, 1'b1, SMAD_TGT_PCI);
		cfg(1'b1, 8'h47, 8'h00);
		rt(32'h000a_0000, 1'b0, 1'b0, 1'b1, SMAD_TGT_PCI);
		cfg(1'b1, 8'h45, 8'h10);
		rt(32'h00ff_ffff, 1'b0, 1'b0, 1'b0, SMAD_TGT_DRAM);
		rt(32'h0100_0000, 1'b0, 1'b0, 1'b0, SMAD_TGT_PCI);
		cfg(1'b1, 8'h46, 8'h03);
		rd(8'h46, 8'h01);
		rd(8'h45, 8'h00);
		rt(32'h0fff_ffff, 1'b0, 1'b0, 1'b0, SMAD_TGT_DRAM);
		$display("test smm_tom done");
	endtask

	task automatic t_bios_bus;
		cfg(1'b1, 8'he3, 8'h00);
		rd(8'he3, 8'h01);
		rt(32'hffc0_0000, 1'b0, 1'b0, 1'b0, SMAD_TGT_PCI);
		rt(32'hffff_ffff, 1'b0, 1'b0, 1'b0, SMAD_TGT_ROM);
		cfg(1'b1, 8'he3, 8'h04);
		rt(32'hffd0_0000, 1'b0, 1'b0, 1'b0, SMAD_TGT_ROM);
		io(17'h1_0002, 1'b1);
		io(17'h1_0003, 1'b0);
		b0(SMAD_ORG_NORTH, 1'b0, 1'b0, 2'b00);
		b0(SMAD_ORG_NORTH, 1'b0, 1'b1, 2'b10);
		b0(SMAD_ORG_SOUTH, 1'b1, 1'b0, 2'b01);
		cfg(1'b1, 8'h48, 8'h01);
		b0(SMAD_ORG_NORTH, 1'b0, 1'b0, 2'b10);
		b0(SMAD_ORG_EXT, 1'b1, 1'b0, 2'b01);
		$display("test bios_bus done");
	endtask

	task automatic conclude;
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// hang guard
	initial
	begin
		#100000;
		bad_count++;
		conclude();
	end

	initial
	begin
		{cfg_sel, cfg_wr, cfg_addr, cfg_wdata, io_valid, io_addr} = '0;
		b0_cyc = '0;
		nrst = 1'b0;
		repeat (16) @(posedge clk_sys);
		nrst <= 1'b1;
		t_reset_map();
		t_attr();
		t_smm_tom();
		t_bios_bus();
		conclude();
	end
endmodule
